// >>> hdl/nfc_host.sv
`timescale 1ns/1ps
// Function
// [RL1] 32-megabit part holds 2,097,152 words
// [RL2] 64-megabit part holds 4,194,304 words
// [RL3] Width select picks 16 or 8 bits
// [RL4] Host drives chip, write, output strobes
// [RL5] Device latches address and data per write
// [RL6] Single sector erase leaves others intact
// [RL7] Sector layouts uniform or with boot sectors
// [RL8] Device ships fully erased
// [RL9] Completion seen by poll, toggle or pin; host watches the pin only
// [RL10] Unlock bypass programs in two writes
// [RL11] Erase suspend allows other-sector reads, programs
// [RL12] Program suspend allows other-sector reads only; host still takes program and erase requests once suspended
// [RL13] Reset pin aborts and readies device
// [RL14] Standby by chip select, reset, idle address
// [RL15] Guard low protects edge sector
// [RL16] Guarded sector stays protected when boosted
// [RL17] Password sectors locked until password given
// [RL18] 128-word secured region, lockable permanently
// [RL19] Secured region holds 8-word serial
// [RL20] 8-word page reads are faster
// [RL21] 16-word write buffer
// [RL22] Device answers the CFI query
// [RL23] No new program or erase while busy
module nfc_host #(
    parameter int unsigned ADDR_W = nfc_pkg::ADDR_W,
    parameter bit          WIDE   = 1'b1
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              opValid,
    input  wire nfc_pkg::nfc_op_t  opCode,
    input  wire logic [ADDR_W-1:0] opAddr,
    input  wire logic [15:0]       opData,
    input  wire logic              bypassEn,
    input  wire logic              guardEn,
    output logic                   opReady,
    output logic                   opDone,
    output logic                   opBusyRefused,
    output logic [15:0]            rdData,
    output logic                   flashBusy,
    output logic [ADDR_W-1:0]      flashAddr,
    output logic [15:0]            dqOut,
    output logic                   dqOe,
    input  wire logic [15:0]       dqIn,
    output logic                   chipSelN,
    output logic                   writeStrobeN,
    output logic                   outEnableN,
    output logic                   resetN,
    output logic                   wordModeN,
    output logic                   write_guard_boost,
    input  wire logic              completion_indicator
);
    typedef enum {ST_IDLE, ST_WSET, ST_WLOW, ST_WHIGH, ST_RD, ST_POLL, ST_RST} nfc_st_t;

    // ============================================================
    // Pin synchronisers
    logic [2:0] rbSync;
    logic [2:0] next_rbSync;
    logic [15:0] dqS1, dqS2, dqS3;
    logic        rbStable, rbReady;
    always_comb begin
        next_rbSync = {rbSync[1:0], completion_indicator};
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rbSync <= 3'h0;
            dqS1   <= 16'h0000;
            dqS2   <= 16'h0000;
            dqS3   <= 16'h0000;
        end else begin
            rbSync <= next_rbSync;
            dqS1   <= dqIn;
            dqS2   <= dqS1;
            dqS3   <= dqS2;
        end
    end
    assign rbStable = rbSync[1] == rbSync[2];
    assign rbReady  = rbStable && rbSync[2]; // RL9

    // ============================================================
    // Sequence builder
    function automatic logic [ADDR_W+15:0] seqWord(input nfc_pkg::nfc_op_t op,
                                                   input logic byp, input int idx,
                                                   input logic [ADDR_W-1:0] a,
                                                   input logic [15:0] d);
        logic [ADDR_W+15:0] u1, u2;
        u1 = {nfc_pkg::UNLOCK_A1, nfc_pkg::UNLOCK_D1};
        u2 = {nfc_pkg::UNLOCK_A2, nfc_pkg::UNLOCK_D2};
        seqWord = {a, d};
        unique case (op)
            nfc_pkg::OP_PROG: begin
                if (byp) seqWord = (idx == 0) ? {a, nfc_pkg::CMD_PROG} : {a, d}; // RL10
                else if (idx == 0) seqWord = u1;
                else if (idx == 1) seqWord = u2;
                else if (idx == 2) seqWord = {nfc_pkg::UNLOCK_A1, nfc_pkg::CMD_PROG};
                else seqWord = {a, d}; // RL5
            end
            nfc_pkg::OP_ERASE: begin
                if (idx == 0 || idx == 3) seqWord = u1;
                else if (idx == 1 || idx == 4) seqWord = u2;
                else if (idx == 2) seqWord = {nfc_pkg::UNLOCK_A1, nfc_pkg::CMD_ERASE};
                else seqWord = {a, nfc_pkg::CMD_SECT}; // RL6
            end
            nfc_pkg::OP_SUSPEND: seqWord = {a, nfc_pkg::CMD_SUSP};
            nfc_pkg::OP_RESUME:  seqWord = {a, nfc_pkg::CMD_RES};
            nfc_pkg::OP_CFI:     seqWord = {nfc_pkg::CFI_A, nfc_pkg::CMD_CFI}; // RL22
            default:             seqWord = {a, nfc_pkg::CMD_RST};
        endcase
    endfunction

    function automatic int seqLen(input nfc_pkg::nfc_op_t op, input logic byp);
        unique case (op)
            nfc_pkg::OP_PROG:  seqLen = byp ? 2 : 4; // RL10
            nfc_pkg::OP_ERASE: seqLen = 6;
            default:           seqLen = 1;
        endcase
    endfunction

    // ============================================================
    // Bus sequencer
    nfc_st_t           st, next_st;
    nfc_pkg::nfc_op_t  op, next_op;
    logic              byp, next_byp;
    logic [2:0]        idx, next_idx;
    logic [nfc_pkg::CNT_W-1:0] cnt, next_cnt;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [15:0]       data, next_data;
    logic              busy, next_busy;
    logic [ADDR_W+15:0] sw;
    logic              cmdOp;

    always_comb begin
        next_st = st; next_op = op; next_byp = byp; next_idx = idx;
        next_cnt = cnt; next_addr = addr; next_data = data; next_busy = busy;
        cmdOp = (opCode == nfc_pkg::OP_PROG) || (opCode == nfc_pkg::OP_ERASE);
        unique case (st)
            ST_IDLE: begin
                if (busy && rbReady) next_busy = 1'b0; // RL9
                if (opValid && !(cmdOp && busy)) begin // RL23
                    next_op = opCode; next_byp = bypassEn;
                    next_addr = opAddr; next_data = opData; next_idx = 3'h0;
                    next_cnt = '0;
                    if (opCode == nfc_pkg::OP_READ) next_st = ST_RD;
                    else if (opCode == nfc_pkg::OP_RESET) next_st = ST_RST; // RL13
                    else next_st = ST_WSET;
                end
            end
            ST_WSET: next_st = ST_WLOW;
            ST_WLOW: begin
                next_cnt = cnt + 1'b1;
                if (cnt == nfc_pkg::CNT_W'(nfc_pkg::WP_CYC - 1)) begin
                    next_cnt = '0; next_st = ST_WHIGH;
                end
            end
            ST_WHIGH: begin
                next_cnt = cnt + 1'b1;
                if (cnt == nfc_pkg::CNT_W'(nfc_pkg::WPH_CYC - 1)) begin
                    next_cnt = '0;
                    if (int'(idx) + 1 < seqLen(op, byp)) begin
                        next_idx = idx + 1'b1; next_st = ST_WSET;
                    end else if (op == nfc_pkg::OP_PROG || op == nfc_pkg::OP_ERASE
                                 || op == nfc_pkg::OP_RESUME) begin
                        next_busy = 1'b1; next_st = ST_POLL;
                    end else begin
                        next_st = ST_IDLE;
                    end
                end
            end
            ST_RD: begin
                next_cnt = cnt + 1'b1;
                if (cnt == nfc_pkg::CNT_W'(nfc_pkg::ACC_CYC + 2)) begin // RL20 not used: every read waits ACC_CYC + 3 cycles, never PAGE_CYC
                    next_data = dqS3; next_st = ST_IDLE;
                end
            end
            ST_POLL: begin
                // Wait a settle time so the pin has gone low before trusting it
                next_cnt = (cnt == '1) ? cnt : cnt + 1'b1;
                if (cnt > nfc_pkg::CNT_W'(nfc_pkg::ACC_CYC) && rbReady) begin // RL9
                    next_busy = 1'b0; next_st = ST_IDLE;
                end else if (opValid && opCode == nfc_pkg::OP_SUSPEND) begin // RL11 RL12
                    next_op = opCode; next_addr = opAddr; next_idx = 3'h0;
                    next_cnt = '0; next_st = ST_WSET;
                end
            end
            ST_RST: begin
                next_cnt = cnt + 1'b1;
                next_busy = 1'b0;
                if (cnt == nfc_pkg::CNT_W'(nfc_pkg::ACC_CYC)) next_st = ST_IDLE;
            end
            default: next_st = ST_IDLE;
        endcase
        // Word of the next state, so address and data move with the strobes
        sw = seqWord(next_op, next_byp, int'(next_idx), next_addr, next_data);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= ST_IDLE; op <= nfc_pkg::OP_READ; byp <= 1'b0; idx <= 3'h0;
            cnt <= '0; addr <= '0; data <= 16'h0000; busy <= 1'b0;
        end else begin
            st <= next_st; op <= next_op; byp <= next_byp; idx <= next_idx;
            cnt <= next_cnt; addr <= next_addr; data <= next_data; busy <= next_busy;
        end
    end

    // ============================================================
    // Registered pins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            opReady <= 1'b0; opDone <= 1'b0; opBusyRefused <= 1'b0;
            rdData <= 16'h0000; flashBusy <= 1'b0; flashAddr <= '0;
            dqOut <= 16'h0000; dqOe <= 1'b0; chipSelN <= 1'b1;
            writeStrobeN <= 1'b1; outEnableN <= 1'b1; resetN <= 1'b0;
            wordModeN <= 1'b1; write_guard_boost <= 1'b0;
        end else begin
            opReady       <= (next_st == ST_IDLE) || (next_st == ST_POLL);
            opDone        <= (st != ST_IDLE) && (next_st == ST_IDLE);
            opBusyRefused <= (st == ST_IDLE || st == ST_POLL) && opValid && cmdOp && busy; // RL23
            rdData        <= (st == ST_RD && next_st == ST_IDLE) ? dqS3 : rdData;
            flashBusy     <= next_busy;
            flashAddr     <= (next_st == ST_WSET || next_st == ST_WLOW || next_st == ST_WHIGH)
                             ? sw[ADDR_W+15:16] : next_addr;
            dqOut         <= sw[15:0]; // RL5
            dqOe          <= (next_st == ST_WSET) || (next_st == ST_WLOW)
                             || (next_st == ST_WHIGH);
            chipSelN      <= !(next_st != ST_IDLE && next_st != ST_RST); // RL4 RL14
            writeStrobeN  <= !(next_st == ST_WLOW); // RL4
            outEnableN    <= !(next_st == ST_RD || next_st == ST_POLL); // RL4
            resetN        <= (next_st != ST_RST); // RL13
            wordModeN     <= WIDE; // RL3
            write_guard_boost <= !guardEn; // RL15 RL16
        end
    end
endmodule

// >>> include/nfc_pkg.sv
package nfc_pkg;
    // Array geometry
    localparam int unsigned WORDS_32M    = 2097152;
    localparam int unsigned WORDS_64M    = 4194304;
    localparam int unsigned ADDR_W       = 22;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned SECURE_WORDS = 128;
    localparam int unsigned SERIAL_WORDS = 8;
    localparam int unsigned PAGE_WORDS   = 8;
    localparam int unsigned WRBUF_WORDS  = 16;
    // Bus timing
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned T_ACC_NS     = 90;
    localparam int unsigned T_PAGE_NS    = 25;
    localparam int unsigned T_WP_NS      = 35;
    localparam int unsigned T_WPH_NS     = 30;
    localparam int unsigned ACC_CYC      = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PAGE_CYC     = (T_PAGE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WP_CYC       = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WPH_CYC      = (T_WPH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W        = 8;
    // Command sequence words
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 22'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 22'h0002aa;
    localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
    localparam logic [15:0] UNLOCK_D2 = 16'h0055;
    localparam logic [15:0] CMD_PROG  = 16'h00a0;
    localparam logic [15:0] CMD_ERASE = 16'h0080;
    localparam logic [15:0] CMD_SECT  = 16'h0030;
    localparam logic [15:0] CMD_BYP   = 16'h0020;
    localparam logic [15:0] CMD_SUSP  = 16'h00b0;
    localparam logic [15:0] CMD_RES   = 16'h0030;
    localparam logic [15:0] CMD_CFI   = 16'h0098;
    localparam logic [ADDR_W-1:0] CFI_A = 22'h000055;
    localparam logic [15:0] CMD_RST   = 16'h00f0;
    localparam int unsigned POLL_BIT   = 7;
    localparam int unsigned TOGGLE_BIT = 6;
    // Host operations
    typedef enum logic [2:0] {
        OP_READ, OP_PROG, OP_ERASE, OP_SUSPEND, OP_RESUME, OP_CFI, OP_RESET
    } nfc_op_t;
endpackage

// >>> tb/nfc_host_checker.sv
`timescale 1ns/1ps
module nfc_host_checker #(
    parameter bit WIDE = 1'b1
) (
    input wire logic              ref_clk,
    input wire logic              nrst,
    input wire logic              opValid,
    input wire nfc_pkg::nfc_op_t  opCode,
    input wire logic              opReady,
    input wire logic              opBusyRefused,
    input wire logic              flashBusy,
    input wire logic [21:0]       flashAddr,
    input wire logic [15:0]       dqOut,
    input wire logic              dqOe,
    input wire logic              chipSelN,
    input wire logic              writeStrobeN,
    input wire logic              outEnableN,
    input wire logic              wordModeN,
    input wire logic              guardEn,
    input wire logic              write_guard_boost,
    input wire logic              completion_indicator
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ========================================
    // Strobes
    a_strobe_excl: assert property (!writeStrobeN |-> !chipSelN && outEnableN)
        else $error("write strobe outside a selected write");
    a_read_release: assert property (!outEnableN |-> !dqOe)
        else $error("bus driven during a read");
    a_write_drive: assert property (!writeStrobeN |-> dqOe)
        else $error("bus not driven during a write");
    // Device latches on the rising strobe, so address and data must hold
    a_write_stable: assert property (!writeStrobeN ##1 !writeStrobeN |->
        $stable(flashAddr) && $stable(dqOut)) else $error("write word moved");
    a_write_width: assert property ($fell(writeStrobeN) |-> !writeStrobeN[*5])
        else $error("write pulse too short");
    a_bus_width: assert property (wordModeN == WIDE)
        else $error("width select wrong");
    // ========================================
    // Completion and guard
    a_busy_hold: assert property (flashBusy && !completion_indicator ##1
        !completion_indicator[*3] |-> flashBusy) else $error("busy dropped early");
    a_refuse_busy: assert property (opValid && opReady && flashBusy &&
        (opCode == nfc_pkg::OP_PROG || opCode == nfc_pkg::OP_ERASE) |-> ##[1:3] opBusyRefused)
        else $error("busy request not refused");
    a_guard_pin: assert property (guardEn ##1 guardEn |-> !write_guard_boost)
        else $error("guard pin not low");
    c_refused: cover property (opBusyRefused);
    c_write: cover property ($fell(writeStrobeN));
    c_busy_end: cover property ($fell(flashBusy));
endmodule

bind nfc_host nfc_host_checker #(.WIDE(WIDE)) chk_u (.*);

// >>> tb/nfc_flash_model.sv
`timescale 1ns/1ps
module nfc_flash_model (
    input  wire logic        ref_clk,
    input  wire logic        resetN,
    input  wire logic        chipSelN,
    input  wire logic        writeStrobeN,
    input  wire logic        outEnableN,
    input  wire logic [21:0] flashAddr,
    input  wire logic [15:0] dqOut,
    input  wire logic        dqOe,
    input  wire logic        write_guard_boost,
    output logic      [15:0] dqIn,
    output logic             completion_indicator
);
    // ========================================
    // Sparse array; 22 address bits, 16-bit words only
    logic [15:0] mem [logic [21:0]];
    logic [1:0]  seq = 2'h0;
    logic        start = 1'b0;
    int          busy = 0;
    // Suspend parks the remaining busy time until resume
    int          held = 0;
    logic        susp = 1'b0;
    logic        suspReq = 1'b0;
    logic        resumeReq = 1'b0;
    wire         guarded = !write_guard_boost && flashAddr[21:15] == 7'h00;
    // Latch on the rising strobe; unlock words leave the armed state alone
    always @(posedge writeStrobeN) begin
        if (!chipSelN && resetN) begin
            if (seq == 2'h1) begin
                if (!guarded) mem[flashAddr] = dqOut;
                seq = 2'h0;
                start = 1'b1;
            end else if (seq == 2'h2 && dqOut == nfc_pkg::CMD_SECT) begin
                if (!guarded) begin
                    foreach (mem[k]) begin
                        if (k[21:15] == flashAddr[21:15]) mem[k] = 16'hffff;
                    end
                end
                seq = 2'h0;
                start = 1'b1;
            end else if (dqOut == nfc_pkg::CMD_SUSP && busy > 0) begin
                susp = 1'b1;
                suspReq = 1'b1;
            end else if (susp && dqOut == nfc_pkg::CMD_RES) begin
                susp = 1'b0;
                resumeReq = 1'b1;
            end else if (dqOut == nfc_pkg::CMD_PROG) seq = 2'h1;
            else if (dqOut == nfc_pkg::CMD_ERASE) seq = 2'h2;
        end
    end
    // Undriven bus flips every cycle so a stale sample cannot pass
    always @(posedge ref_clk or negedge resetN) begin
        if (!resetN) begin
            busy = 0;
            seq = 2'h0;
            susp = 1'b0;
        end else if (start) begin
            busy = 100;
            start = 1'b0;
        end else if (suspReq) begin
            held = busy;
            busy = 0;
            suspReq = 1'b0;
        end else if (resumeReq) begin
            busy = held;
            resumeReq = 1'b0;
        end else if (busy > 0) busy = busy - 1;
        if (!chipSelN && !outEnableN && !dqOe) begin
            dqIn <= mem.exists(flashAddr) ? mem[flashAddr] : 16'hffff;
        end else dqIn <= ~dqIn;
    end
    assign completion_indicator = (busy == 0);
endmodule

// >>> tb/nfc_host_bench.sv
`timescale 1ns/1ps
module nfc_host_bench;
    logic              ref_clk;
    logic              nrst;
    logic              opValid;
    nfc_pkg::nfc_op_t  opCode;
    logic [21:0]       opAddr, flashAddr;
    logic [15:0]       opData, rdData, dqOut, dqIn;
    logic              bypassEn, guardEn, opReady, opDone, opBusyRefused, flashBusy, dqOe;
    logic              chipSelN, writeStrobeN, outEnableN, resetN, wordModeN;
    logic              write_guard_boost, completion_indicator;
    int                err_count = 0;
    int                n_compared = 0;
    nfc_host #(.WIDE(1'b1)) dut_u (.*);
    nfc_flash_model model_u (.*);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ========================================
    // Tasks
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request is taken on the edge after a negedge that sees opReady
    task automatic req(input nfc_pkg::nfc_op_t op, input logic [21:0] a, input logic [15:0] d);
        int i;
        @(negedge ref_clk);
        opValid = 1'b1;
        opCode = op;
        opAddr = a;
        opData = d;
        for (i = 0; i < 400 && opReady !== 1'b1; i++) @(negedge ref_clk);
        if (opReady !== 1'b1) begin
            check16(16'h0000, 16'h0001);
            end_of_test;
        end
        @(negedge ref_clk);
        opValid = 1'b0;
    endtask
    // Pulses stand one cycle, so the first look is made at once
    task automatic wait_pulse(input bit refused);
        int i;
        for (i = 0; i < 400; i++) begin
            if ((refused ? opBusyRefused : opDone) === 1'b1) return;
            @(negedge ref_clk);
        end
        check16(16'h0000, 16'h0001);
        end_of_test;
    endtask
    task automatic rd(input logic [21:0] a, input logic [15:0] exp);
        req(nfc_pkg::OP_READ, a, 16'h0000);
        wait_pulse(1'b0);
        check16(rdData, exp);
    endtask
    task automatic prog(input logic [21:0] a, input logic [15:0] d);
        req(nfc_pkg::OP_PROG, a, d);
        wait_pulse(1'b0);
    endtask
    // ========================================
    // Sequence
    initial begin
        nrst = 1'b0;
        opValid = 1'b0;
        opCode = nfc_pkg::OP_READ;
        opAddr = 22'h000000;
        opData = 16'h0000;
        bypassEn = 1'b0;
        guardEn = 1'b0;
        repeat (6) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        check16({15'h0000, resetN}, 16'h0001);
        rd(22'h012345, 16'hffff);
        $display("Test reset and erased read done");
        req(nfc_pkg::OP_PROG, 22'h010010, 16'h1234);
        req(nfc_pkg::OP_PROG, 22'h018020, 16'h0000);
        wait_pulse(1'b1);
        wait_pulse(1'b0);
        rd(22'h010010, 16'h1234);
        $display("Test program and busy refusal done");
        bypassEn = 1'b1;
        prog(22'h018020, 16'h5a5a);
        bypassEn = 1'b0;
        rd(22'h018020, 16'h5a5a);
        $display("Test bypass program done");
        req(nfc_pkg::OP_ERASE, 22'h010010, 16'h0000);
        wait_pulse(1'b0);
        rd(22'h010010, 16'hffff);
        rd(22'h018020, 16'h5a5a);
        $display("Test sector erase done");
        req(nfc_pkg::OP_ERASE, 22'h018020, 16'h0000);
        req(nfc_pkg::OP_SUSPEND, 22'h018020, 16'h0000);
        wait_pulse(1'b0);
        rd(22'h010010, 16'hffff);
        prog(22'h010010, 16'ha5a5);
        rd(22'h010010, 16'ha5a5);
        req(nfc_pkg::OP_RESUME, 22'h018020, 16'h0000);
        wait_pulse(1'b0);
        check16({15'h0000, flashBusy}, 16'h0000);
        rd(22'h018020, 16'hffff);
        $display("Test erase suspend done");
        req(nfc_pkg::OP_RESET, 22'h000000, 16'h0000);
        wait_pulse(1'b0);
        check16({15'h0000, resetN}, 16'h0001);
        check16({15'h0000, flashBusy}, 16'h0000);
        rd(22'h010010, 16'ha5a5);
        $display("Test reset operation done");
        guardEn = 1'b1;
        prog(22'h000100, 16'h0000);
        rd(22'h000100, 16'hffff);
        guardEn = 1'b0;
        prog(22'h000100, 16'h0000);
        rd(22'h000100, 16'h0000);
        $display("Test edge guard done");
        end_of_test;
    end
endmodule
